// ===== logic/tuc_pkg.sv
`default_nettype none
package tuc_pkg;
   // Register bus geometry
   localparam int TUC_ADDR_W = 4;
   localparam int TUC_DATA_W = 16;

   // Register offsets
   localparam logic [3:0] TUC_OFF_RESET_CTRL = 4'h0;
   localparam logic [3:0] TUC_OFF_CLOCK_EN   = 4'h1;
   localparam logic [3:0] TUC_OFF_PRESCALE   = 4'h2;
   localparam logic [3:0] TUC_OFF_STOP       = 4'h3;
   localparam logic [3:0] TUC_OFF_INSEL      = 4'h4;
   localparam logic [3:0] TUC_OFF_MODE       = 4'h5;
   localparam logic [3:0] TUC_OFF_START      = 4'h6;
   localparam logic [3:0] TUC_OFF_STATUS     = 4'h7;
   localparam logic [3:0] TUC_OFF_COUNT      = 4'h8;

   // Values after reset
   localparam logic        TUC_RESET_CTRL_RST = 1'b0;
   localparam logic        TUC_CLOCK_EN_RST   = 1'b0;
   localparam logic [15:0] TUC_PRESCALE_RST   = 16'h0000;
   localparam logic [2:0]  TUC_INSEL_RST      = 3'h0;
   localparam logic [15:0] TUC_MODE_RST       = 16'h0000;

   // Implemented bits
   localparam logic [15:0] TUC_PRESCALE_MASK = 16'h33ff;
   localparam logic [15:0] TUC_MODE_MASK     = 16'hdfcf;

   // Prescaler field positions
   localparam int TUC_PS_A_LSB = 0;
   localparam int TUC_PS_B_LSB = 4;
   localparam int TUC_PS_C_LSB = 8;
   localparam int TUC_PS_D_LSB = 12;
   localparam logic [3:0] TUC_PS_C_BASE = 4'h2;
   localparam logic [3:0] TUC_PS_D_BASE = 4'h8;
   localparam int TUC_PS_CNT_W = 15;

   // Mode register field positions
   localparam int TUC_MD_LSB    = 0;
   localparam int TUC_CIS_LSB   = 6;
   localparam int TUC_STS_LSB   = 8;
   localparam int TUC_SPLIT_BIT = 11;
   localparam int TUC_CCS_BIT   = 12;
   localparam int TUC_CKS_LSB   = 14;

   // Stop and start register bit positions
   localparam int TUC_HALF1_BIT = 9;
   localparam int TUC_HALF3_BIT = 11;
   localparam int TUC_RUN_W     = 6;

   // Channel 1 input selector codes
   typedef enum logic [2:0] {
      TUC_IN_PIN_A = 3'h0,
      TUC_IN_EVENT = 3'h1,
      TUC_IN_PIN_B = 3'h2,
      TUC_IN_MID   = 3'h3,
      TUC_IN_LOW   = 3'h4,
      TUC_IN_SUB   = 3'h5
   } tuc_insel_e;

   // Synchroniser lanes
   localparam int TUC_LANE_PIN   = 0;
   localparam int TUC_LANE_EVENT = 1;
   localparam int TUC_LANE_MID   = 2;
   localparam int TUC_LANE_LOW   = 3;
   localparam int TUC_LANE_SUB   = 4;
   localparam int TUC_LANES      = 5;
endpackage
`default_nettype wire

// ===== logic/tuc_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module tuc_sync3 #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rstn,
   input  wire logic [W-1:0] i_async,
   output var  logic [W-1:0] o_level
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;
   wire  [W-1:0] agree = ~(s2_q ^ s3_q);
   wire  [W-1:0] lvl_d = (agree & s3_q) | (~agree & lvl_q);

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         lvl_q <= '0;
      end else begin
         s1_q  <= i_async;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign o_level = lvl_q;
endmodule
`default_nettype wire

// ===== logic/tuc_top.sv
//////////////////////////////////////////////////////////////////////////////
// Contract
// R1: Reset control bit at 1 holds whole timer unit reset; writing 0 releases.
// R2: Clock gate bit 0 stops unit input clock; 1 supplies it.
// R3: First prescaler field picks peripheral clock divided by two to its value.
// R4: Prescaler register holds fields at 3-0, 7-4, 9-8, 13-12; rest zero.
// R5: Writing 1 to a stop bit clears that channel's running flag, halting it; a same-cycle hardware start of channel 1 wins and keeps it set.
// R6: Stop bits 0 to 3 for channels, 9 and 11 for upper halves.
// R7: Input select routes pin, event link, middle, low or subsystem clock.
// R8: Clock pick field 15-14: 00 a, 01 c, 10 b, 11 d.
// R9: Count source bit picks prescaled clock or valid input edges.
// R10: Trigger select 000 allows only a software start.
// R11: Mode field picks listed operation modes; other codes are prohibited.
// R12: Channel 1 input edges come from the selected input source.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module tuc_top
   import tuc_pkg::*;
(
   input  wire logic                          I_CLK,
   input  wire logic                          I_RSTN,
   input  wire logic [tuc_pkg::TUC_ADDR_W-1:0] I_ADDR,
   input  wire logic [tuc_pkg::TUC_DATA_W-1:0] I_WDATA,
   input  wire logic                          I_WR,
   input  wire logic                          I_RD,
   input  wire logic                          I_TIMER_PIN,
   input  wire logic                          I_EVENT_LINK,
   input  wire logic                          I_MID_OSC,
   input  wire logic                          I_LOW_OSC,
   input  wire logic                          I_SUB_CLK,
   output var  logic [tuc_pkg::TUC_DATA_W-1:0] O_RDATA,
   output var  logic                          O_UNIT_IN_RESET,
   output var  logic                          O_UNIT_CLOCK_ON,
   output var  logic [3:0]                    O_PRESCALED_TICK,
   output var  logic                          O_CH1_COUNT_TICK,
   output var  logic [tuc_pkg::TUC_RUN_W-1:0]  O_RUN_FLAGS,
   output var  logic [tuc_pkg::TUC_DATA_W-1:0] O_CH1_COUNT,
   output var  logic                          O_CH1_MODE_BAD,
   output var  logic                          O_CH1_INPUT_BAD
);
   import tuc_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // Functions

   // Tick when the low exp bits of the counter are all ones
   function automatic logic pscl_tick(input logic [TUC_PS_CNT_W-1:0] cnt, input logic [3:0] exp);
      logic [TUC_PS_CNT_W-1:0] mask;
      mask = TUC_PS_CNT_W'((16'h0001 << exp) - 16'h0001);
      return &(cnt | ~mask);
   endfunction

   // Stop or start word to run flag vector
   function automatic logic [TUC_RUN_W-1:0] run_bits(input logic [15:0] w);
      return {w[TUC_HALF3_BIT], w[TUC_HALF1_BIT], w[3:0]};
   endfunction

   // Listed operation mode codes
   function automatic logic md_ok(input logic [3:0] md);
      return (md == 4'h0) || (md == 4'h1) || (md == 4'h4) || (md == 4'h5) ||
             (md == 4'h6) || (md == 4'h8) || (md == 4'h9) || (md == 4'hc);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Registers

   logic                    reset_ctrl_q;
   logic                    clk_gate_q;
   logic [15:0]             ps_q;
   logic [2:0]              insel_q;
   logic [15:0]             mode_q;
   logic [TUC_PS_CNT_W-1:0] pscl_cnt_q;
   logic [3:0]              tick_q;
   logic [TUC_RUN_W-1:0]    run_q;
   logic [15:0]             ch1_cnt_q;
   logic                    count_tick_q;
   logic                    in_prev_q;
   logic [15:0]             rdata_q;
   logic                    mode_bad_q;
   logic                    input_bad_q;
   logic [TUC_LANES-1:0]    lvl;

   //////////////////////////////////////////////////////////////////////////
   // Decode

   wire unit_rst = reset_ctrl_q;
   wire unit_on  = clk_gate_q & ~reset_ctrl_q;

   wire wr_reset = I_WR && (I_ADDR == TUC_OFF_RESET_CTRL);
   wire wr_clken = I_WR && (I_ADDR == TUC_OFF_CLOCK_EN);
   wire wr_ps    = I_WR && (I_ADDR == TUC_OFF_PRESCALE) && unit_on;
   wire wr_stop  = I_WR && (I_ADDR == TUC_OFF_STOP) && unit_on;
   wire wr_insel = I_WR && (I_ADDR == TUC_OFF_INSEL) && unit_on;
   wire wr_mode  = I_WR && (I_ADDR == TUC_OFF_MODE) && unit_on;
   wire wr_start = I_WR && (I_ADDR == TUC_OFF_START) && unit_on;

   wire [3:0] exp_a = ps_q[TUC_PS_A_LSB +: 4];
   wire [3:0] exp_b = ps_q[TUC_PS_B_LSB +: 4];
   wire [3:0] exp_c = {1'b0, ps_q[TUC_PS_C_LSB +: 2], 1'b0} + TUC_PS_C_BASE;
   wire [3:0] exp_d = {1'b0, ps_q[TUC_PS_D_LSB +: 2], 1'b0} + TUC_PS_D_BASE;

   wire [1:0] cks   = mode_q[TUC_CKS_LSB +: 2];
   wire       ccs   = mode_q[TUC_CCS_BIT];
   wire [2:0] sts   = mode_q[TUC_STS_LSB +: 3];
   wire [1:0] cis   = mode_q[TUC_CIS_LSB +: 2];
   wire [3:0] md    = mode_q[TUC_MD_LSB +: 4];

   //////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   tuc_sync3 #(
      .W (TUC_LANES)
   ) u_sync (
      .i_clk   (I_CLK),
      .i_rstn  (I_RSTN),
      .i_async ({I_SUB_CLK, I_LOW_OSC, I_MID_OSC, I_EVENT_LINK, I_TIMER_PIN}),
      .o_level (lvl)
   );

   //////////////////////////////////////////////////////////////////////////
   // Selection

   // Channel 1 input source, prohibited codes route nothing
   wire sel_lvl =
      (insel_q == TUC_IN_PIN_A) ? lvl[TUC_LANE_PIN]   :      // R7
      (insel_q == TUC_IN_PIN_B) ? lvl[TUC_LANE_PIN]   :
      (insel_q == TUC_IN_EVENT) ? lvl[TUC_LANE_EVENT] :
      (insel_q == TUC_IN_MID)   ? lvl[TUC_LANE_MID]   :
      (insel_q == TUC_IN_LOW)   ? lvl[TUC_LANE_LOW]   :
      (insel_q == TUC_IN_SUB)   ? lvl[TUC_LANE_SUB]   : 1'b0;

   // Valid edge of the selected input
   wire in_rise    = sel_lvl & ~in_prev_q;                  // R12
   wire in_fall    = ~sel_lvl & in_prev_q;
   wire edge_valid = unit_on & ((cis == 2'b00) ? in_fall :
                                (cis == 2'b01) ? in_rise : (in_rise | in_fall));

   // Prescaled clock ticks
   wire [3:0] tick_d = {4{unit_on}} & {pscl_tick(pscl_cnt_q, exp_d),
                                        pscl_tick(pscl_cnt_q, exp_c),
                                        pscl_tick(pscl_cnt_q, exp_b),
                                        pscl_tick(pscl_cnt_q, exp_a)};   // R3

   // Channel operation clock pick
   wire pick_tick = (cks == 2'b00) ? tick_q[0] :             // R8
                    (cks == 2'b01) ? tick_q[2] :
                    (cks == 2'b10) ? tick_q[1] : tick_q[3];

   // Count source for channel 1
   wire count_tick_d = unit_on & run_q[1] & (ccs ? edge_valid : pick_tick);   // R9

   // Start triggers: software always, selected input edges only when sts selects them
   wire hw_start = ((sts == 3'b001) & edge_valid) |           // R10
                   ((sts == 3'b010) & unit_on & (in_rise | in_fall));
   wire [TUC_RUN_W-1:0] start_bits = (wr_start ? run_bits(I_WDATA) : '0) |
                                      {4'h0, hw_start, 1'b0};
   wire [TUC_RUN_W-1:0] stop_bits  = wr_stop ? run_bits(I_WDATA) : '0;   // R6
   wire [TUC_RUN_W-1:0] run_d      = (run_q & ~stop_bits) | start_bits;  // R5

   wire [15:0] status_word = {4'h0, run_q[5], 1'b0, run_q[4], 5'h00, run_q[3:0]};

   // Read mux; unit registers read zero while the unit is off
   wire [15:0] rdata_d =
      !I_RD                                           ? 16'h0000 :
      (I_ADDR == TUC_OFF_RESET_CTRL)                  ? {15'h0000, reset_ctrl_q} :
      (I_ADDR == TUC_OFF_CLOCK_EN)                    ? {15'h0000, clk_gate_q} :
      !unit_on                                        ? 16'h0000 :
      (I_ADDR == TUC_OFF_PRESCALE)                    ? ps_q :
      (I_ADDR == TUC_OFF_INSEL)                       ? {13'h0000, insel_q} :
      (I_ADDR == TUC_OFF_MODE)                        ? mode_q :
      (I_ADDR == TUC_OFF_STATUS)                      ? status_word :
      (I_ADDR == TUC_OFF_COUNT)                       ? ch1_cnt_q : 16'h0000;

   //////////////////////////////////////////////////////////////////////////
   // Always-on control

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         reset_ctrl_q <= TUC_RESET_CTRL_RST;
         clk_gate_q   <= TUC_CLOCK_EN_RST;
      end else begin
         if (wr_reset) begin
            reset_ctrl_q <= I_WDATA[0];                       // R1
         end
         if (wr_clken) begin
            clk_gate_q <= I_WDATA[0];                         // R2
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Unit configuration

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         ps_q    <= TUC_PRESCALE_RST;
         insel_q <= TUC_INSEL_RST;
         mode_q  <= TUC_MODE_RST;
      end else if (unit_rst) begin
         ps_q    <= TUC_PRESCALE_RST;                         // R1
         insel_q <= TUC_INSEL_RST;
         mode_q  <= TUC_MODE_RST;
      end else begin
         if (wr_ps) begin
            ps_q <= I_WDATA & TUC_PRESCALE_MASK;              // R4
         end
         if (wr_insel) begin
            insel_q <= I_WDATA[2:0];
         end
         if (wr_mode) begin
            mode_q <= I_WDATA & TUC_MODE_MASK;                // R11
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Unit state

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         pscl_cnt_q   <= '0;
         tick_q       <= 4'h0;
         run_q        <= '0;
         ch1_cnt_q    <= 16'h0000;
         count_tick_q <= 1'b0;
         in_prev_q    <= 1'b0;
      end else if (unit_rst) begin
         pscl_cnt_q   <= '0;                                  // R1
         tick_q       <= 4'h0;
         run_q        <= '0;
         ch1_cnt_q    <= 16'h0000;
         count_tick_q <= 1'b0;
         in_prev_q    <= 1'b0;
      end else begin
         tick_q       <= tick_d;
         count_tick_q <= count_tick_d;
         run_q        <= run_d;
         if (clk_gate_q) begin
            pscl_cnt_q <= pscl_cnt_q + 1'b1;                  // R2
            in_prev_q  <= sel_lvl;
         end
         if (count_tick_d) begin
            ch1_cnt_q <= ch1_cnt_q + 16'h0001;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read data and flags

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rdata_q     <= 16'h0000;
         mode_bad_q  <= 1'b0;
         input_bad_q <= 1'b0;
      end else begin
         rdata_q     <= rdata_d;
         mode_bad_q  <= ~md_ok(md);                           // R11
         input_bad_q <= (insel_q > TUC_IN_SUB);               // R7
      end
   end

   assign O_RDATA          = rdata_q;
   assign O_UNIT_IN_RESET  = reset_ctrl_q;
   assign O_UNIT_CLOCK_ON  = clk_gate_q;
   assign O_PRESCALED_TICK = tick_q;
   assign O_CH1_COUNT_TICK = count_tick_q;
   assign O_RUN_FLAGS      = run_q;
   assign O_CH1_COUNT      = ch1_cnt_q;
   assign O_CH1_MODE_BAD   = mode_bad_q;
   assign O_CH1_INPUT_BAD  = input_bad_q;

   //////////////////////////////////////////////////////////////////////////
   // Assertions

   unit_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R1
      reset_ctrl_q |=> (run_q == '0) && (ch1_cnt_q == 16'h0000) && (ps_q == 16'h0000))
      else $error("unit not held in reset");

   gate_freeze_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R2
      (!clk_gate_q && !reset_ctrl_q) |=> $stable(pscl_cnt_q) && $stable(ch1_cnt_q) && (tick_q == 4'h0))
      else $error("unit advanced with clock gated");

   div_one_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R3
      (unit_on && (exp_a == 4'h0)) |=> tick_q[0])
      else $error("divide by one tick missing");

   div_two_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R3
      (unit_on && (exp_a == 4'h1) && tick_q[0] && $stable(ps_q)) |=> !tick_q[0])
      else $error("divide by two ticked twice in a row");

   ps_layout_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R4
      (ps_q & ~TUC_PRESCALE_MASK) == 16'h0000)
      else $error("unused prescaler bits set");

   stop_clears_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R5
      (wr_stop && I_WDATA[1] && !hw_start) |=> !run_q[1] ##1 !count_tick_q)
      else $error("channel 1 not stopped");

   half_stop_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R6
      (wr_stop && I_WDATA[TUC_HALF1_BIT] && I_WDATA[TUC_HALF3_BIT]) |=> (run_q[5:4] == 2'b00))
      else $error("upper half stop bits ignored");

   insel_route_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R7
      (insel_q == TUC_IN_LOW) |-> (sel_lvl == lvl[TUC_LANE_LOW]))
      else $error("low oscillator not routed");

   cks_pick_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R8
      (cks == 2'b01) |-> (pick_tick == tick_q[2]))
      else $error("clock pick 01 not third clock");

   ccs_src_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R9
      (!ccs && unit_on && run_q[1] && pick_tick) |=> O_CH1_COUNT_TICK && (ch1_cnt_q == $past(ch1_cnt_q) + 16'h0001))
      else $error("prescaled tick not counted");

   sw_only_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R10
      ((sts == 3'b000) && !(wr_start && I_WDATA[1])) |=> (!run_q[1] || $stable(run_q[1])))
      else $error("channel started without software");

   mode_bad_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R11
      (md == 4'h2) |=> O_CH1_MODE_BAD)
      else $error("prohibited mode not flagged");

   edge_count_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R12
      (ccs && run_q[1] && edge_valid) |=> O_CH1_COUNT_TICK)
      else $error("selected input edge not counted");

   cfg_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R1
      reset_ctrl_q |=> (mode_q == TUC_MODE_RST) && (insel_q == TUC_INSEL_RST) && (tick_q == 4'h0))
      else $error("unit config not cleared");

   off_write_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R2
      (I_WR && !clk_gate_q && !reset_ctrl_q && (I_ADDR == TUC_OFF_PRESCALE)) |=> $stable(ps_q))
      else $error("prescaler written with clock gated");

   off_read_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R2
      (I_RD && !unit_on && (I_ADDR >= TUC_OFF_PRESCALE)) |=> (O_RDATA == 16'h0000))
      else $error("unit register read with unit off");

   cnt_wrap_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R3
      (unit_on && (pscl_cnt_q == '1)) |=> (tick_q == 4'hf))
      else $error("prescaler wrap missed a tick");

   ps_write_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R4
      wr_ps |=> (ps_q == ($past(I_WDATA) & TUC_PRESCALE_MASK)))
      else $error("prescaler write not stored");

   stop_ch0_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R6
      (wr_stop && I_WDATA[0]) |=> !run_q[0])
      else $error("channel 0 not stopped");

   insel_null_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R7
      (insel_q > TUC_IN_SUB) |-> !sel_lvl)
      else $error("prohibited input code routed");

   insel_bad_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R7
      (insel_q > TUC_IN_SUB) |=> O_CH1_INPUT_BAD)
      else $error("prohibited input code not flagged");

   cks_b_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R8
      (cks == 2'b10) |-> (pick_tick == tick_q[1]))
      else $error("clock pick 10 not second clock");

   ccs_edge_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)   // R9
      (ccs && !edge_valid) |=> !O_CH1_COUNT_TICK)
      else $error("edge count without valid edge");
endmodule
`default_nettype wire

// ===== verification/tuc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tuc_top_tb;
   import tuc_pkg::*;

   logic                  i_clk;
   logic                  i_rstn;
   logic [TUC_ADDR_W-1:0] i_addr;
   logic [TUC_DATA_W-1:0] i_wdata;
   logic                  i_wr;
   logic                  i_rd;
   logic [TUC_LANES-1:0]  src;
   logic [TUC_DATA_W-1:0] o_rdata;
   logic                  o_unit_in_reset;
   logic                  o_unit_clock_on;
   logic [3:0]            o_prescaled_tick;
   logic                  o_ch1_count_tick;
   logic [TUC_RUN_W-1:0]  o_run_flags;
   logic [TUC_DATA_W-1:0] o_ch1_count;
   logic                  o_ch1_mode_bad;
   logic                  o_ch1_input_bad;
   int                    failures;
   int                    comparisons;

   tuc_top u_dut (
      .I_CLK            (i_clk),
      .I_RSTN           (i_rstn),
      .I_ADDR           (i_addr),
      .I_WDATA          (i_wdata),
      .I_WR             (i_wr),
      .I_RD             (i_rd),
      .I_TIMER_PIN      (src[TUC_LANE_PIN]),
      .I_EVENT_LINK     (src[TUC_LANE_EVENT]),
      .I_MID_OSC        (src[TUC_LANE_MID]),
      .I_LOW_OSC        (src[TUC_LANE_LOW]),
      .I_SUB_CLK        (src[TUC_LANE_SUB]),
      .O_RDATA          (o_rdata),
      .O_UNIT_IN_RESET  (o_unit_in_reset),
      .O_UNIT_CLOCK_ON  (o_unit_clock_on),
      .O_PRESCALED_TICK (o_prescaled_tick),
      .O_CH1_COUNT_TICK (o_ch1_count_tick),
      .O_RUN_FLAGS      (o_run_flags),
      .O_CH1_COUNT      (o_ch1_count),
      .O_CH1_MODE_BAD   (o_ch1_mode_bad),
      .O_CH1_INPUT_BAD  (o_ch1_input_bad)
   );

   always #2 i_clk = ~i_clk;

   //////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   task automatic count_ticks(input int n, input int idx, output int c);
      c = 0;
      repeat (n) begin
         @(posedge i_clk);
         #1;
         if (((idx < 4) ? o_prescaled_tick[idx] : o_ch1_count_tick) === 1'b1) c++;
      end
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic sc_reset_and_gate();
      logic [15:0] d;
      rd(TUC_OFF_CLOCK_EN, d);
      chk("clock_en_reset", d, 16'h0000);
      @(posedge i_clk);
      #1;
      chk("rdata_one_cycle", o_rdata, 16'h0000);
      wr(TUC_OFF_PRESCALE, 16'h0003);
      wr(TUC_OFF_CLOCK_EN, 16'h0001);
      chk("clock_on", {15'h0, o_unit_clock_on}, 16'h0001);
      rd(TUC_OFF_PRESCALE, d);
      chk("prescale_write_while_off", d, 16'h0000);
      wr(TUC_OFF_PRESCALE, 16'hffff);
      rd(TUC_OFF_PRESCALE, d);
      chk("prescale_mask", d, 16'h33ff);
      rd(4'hf, d);
      chk("unmapped_read", d, 16'h0000);
   endtask

   task automatic sc_prescale_a();
      int c;
      for (int e = 0; e < 8; e++) begin
         wr(TUC_OFF_PRESCALE, 16'(e));
         count_ticks(256, 0, c);
         chk("tick_a_count", 16'(c), 16'(256 >> e));
      end
      wr(TUC_OFF_PRESCALE, 16'h000f);
      count_ticks(65536, 0, c);
      chk("tick_a_max", 16'(c), 16'h0002);
   endtask

   task automatic sc_clock_pick();
      int c;
      int exp_cnt [4] = '{256, 64, 128, 1};
      int tick_cnt [4] = '{256, 128, 64, 1};
      wr(TUC_OFF_PRESCALE, 16'h0010);
      for (int k = 0; k < 4; k++) begin
         count_ticks(256, k, c);
         chk("tick_count", 16'(c), 16'(tick_cnt[k]));
      end
      wr(TUC_OFF_START, 16'h0002);
      for (int k = 0; k < 4; k++) begin
         wr(TUC_OFF_MODE, 16'(k) << TUC_CKS_LSB);
         count_ticks(256, 4, c);
         chk("pick_count", 16'(c), 16'(exp_cnt[k]));
      end
   endtask

   task automatic sc_stop();
      logic [15:0] d;
      logic [15:0] c0;
      wr(TUC_OFF_START, 16'h0a0f);
      chk("run_all", 16'(o_run_flags), 16'h003f);
      rd(TUC_OFF_STATUS, d);
      chk("status_all", d, 16'h0a0f);
      wr(TUC_OFF_STOP, 16'h0002);
      chk("stop_ch1", 16'(o_run_flags), 16'h003d);
      rd(TUC_OFF_COUNT, c0);
      repeat (20) @(posedge i_clk);
      rd(TUC_OFF_COUNT, d);
      chk("count_frozen", d, c0);
      wr(TUC_OFF_STOP, 16'h0a00);
      chk("stop_halves", 16'(o_run_flags), 16'h000d);
      rd(TUC_OFF_STOP, d);
      chk("stop_reads_zero", d, 16'h0000);
      wr(TUC_OFF_STOP, 16'h000d);
      chk("stop_rest", 16'(o_run_flags), 16'h0000);
   endtask

   task automatic sc_modes();
      logic [15:0] d;
      logic [15:0] ok = 16'h1373;
      for (int m = 0; m < 16; m++) begin
         wr(TUC_OFF_MODE, 16'h2000 | 16'(m));
         repeat (2) @(posedge i_clk);
         #1;
         chk("mode_bad", 16'(o_ch1_mode_bad), 16'(!ok[m]));
      end
      rd(TUC_OFF_MODE, d);
      chk("mode_mask", d, 16'h000f);
   endtask

   task automatic sc_trigger();
      wr(TUC_OFF_INSEL, 16'h0000);
      wr(TUC_OFF_MODE, 16'h1080);
      repeat (12) @(posedge i_clk);
      repeat (2) begin
         src[TUC_LANE_PIN] <= ~src[TUC_LANE_PIN];
         repeat (10) @(posedge i_clk);
      end
      #1;
      chk("no_hw_start", 16'(o_run_flags[1]), 16'h0000);
      wr(TUC_OFF_MODE, 16'h1180);
      repeat (12) @(posedge i_clk);
      src[TUC_LANE_PIN] <= ~src[TUC_LANE_PIN];
      repeat (12) @(posedge i_clk);
      #1;
      chk("edge_start", 16'(o_run_flags[1]), 16'h0001);
   endtask

   task automatic sc_input_select();
      logic [15:0] c0;
      logic [15:0] c1;
      int lane [6] = '{TUC_LANE_PIN, TUC_LANE_EVENT, TUC_LANE_PIN, TUC_LANE_MID, TUC_LANE_LOW, TUC_LANE_SUB};
      int l;
      int o;
      wr(TUC_OFF_MODE, 16'h1080);
      wr(TUC_OFF_START, 16'h0002);
      for (int s = 0; s < 7; s++) begin
         l = lane[s % 6];
         o = (l + 1) % TUC_LANES;
         wr(TUC_OFF_INSEL, 16'(s));
         repeat (12) @(posedge i_clk);
         rd(TUC_OFF_COUNT, c0);
         for (int k = 0; k < 4; k++) begin
            src[l] <= ~src[l];
            if (k < 3) src[o] <= ~src[o];
            repeat (10) @(posedge i_clk);
         end
         repeat (10) @(posedge i_clk);
         rd(TUC_OFF_COUNT, c1);
         chk("input_edges", c1 - c0, (s < 6) ? 16'h0004 : 16'h0000);
         chk("input_bad", 16'(o_ch1_input_bad), (s < 6) ? 16'h0000 : 16'h0001);
      end
   endtask

   task automatic sc_unit_reset();
      logic [15:0] d;
      wr(TUC_OFF_PRESCALE, 16'h0123);
      @(posedge i_clk);
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      chk("rst_clock_off", 16'(o_unit_clock_on), 16'h0000);
      chk("rst_run_clear", 16'(o_run_flags), 16'h0000);
      chk("rst_count_clear", o_ch1_count, 16'h0000);
      @(posedge i_clk);
      i_rstn <= 1'b1;
      rd(TUC_OFF_MODE, d);
      chk("mode_read_off", d, 16'h0000);
      wr(TUC_OFF_CLOCK_EN, 16'h0001);
      rd(TUC_OFF_PRESCALE, d);
      chk("prescale_after_rst", d, 16'h0000);
   endtask

   task automatic sc_unit_hold();
      logic [15:0] d;
      wr(TUC_OFF_PRESCALE, 16'h0123);
      wr(TUC_OFF_RESET_CTRL, 16'h0001);
      chk("unit_in_reset", 16'(o_unit_in_reset), 16'h0001);
      repeat (2) @(posedge i_clk);
      #1;
      chk("reset_clears_run", 16'(o_run_flags), 16'h0000);
      wr(TUC_OFF_PRESCALE, 16'h0011);
      wr(TUC_OFF_RESET_CTRL, 16'h0000);
      chk("unit_released", 16'(o_unit_in_reset), 16'h0000);
      rd(TUC_OFF_PRESCALE, d);
      chk("prescale_cleared", d, 16'h0000);
   endtask

   //////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      i_clk       = 1'b0;
      i_rstn      = 1'b0;
      i_addr      = '0;
      i_wdata     = '0;
      i_wr        = 1'b0;
      i_rd        = 1'b0;
      src         = '0;
      failures    = 0;
      comparisons = 0;
      repeat (8) @(posedge i_clk);
      i_rstn <= 1'b1;
      sc_reset_and_gate();
      sc_prescale_a();
      sc_clock_pick();
      sc_stop();
      sc_modes();
      sc_trigger();
      sc_input_select();
      sc_unit_reset();
      sc_unit_hold();
      print_verdict();
   end

   initial begin
      repeat (95000) @(posedge i_clk);
      failures++;
      print_verdict();
   end
endmodule
`default_nettype wire
